// *** logic/fanlut_entries.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module fanlut_entries #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address channel
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // Write data channel
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // Read data channel
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Filtered remote temperature from the same clock domain
    input  wire logic [10:0]       remote_temp,
    // Fan duty request
    output logic                   entry4_active,
    output logic                   entry5_active,
    output logic [7:0]             entry4_duty,
    output logic                   duty_hires_active
);

    if (ADDR_W < 10) begin : g_addr_chk
        $error("fanlut_entries: ADDR_W must be at least 10");
    end

    typedef enum logic [1:0] {
        FANLUT_IDLE  = 2'b00,
        FANLUT_WRESP = 2'b01,
        FANLUT_RRESP = 2'b10
    } fanlut_bus_t;

    typedef struct packed {
        fanlut_bus_t st;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_idx;
        logic        aw_ok;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  cfg;
        logic [7:0]  tbl_offset;
        logic [7:0]  e4_limit;
        logic [7:0]  e4_duty;
        logic [7:0]  e5_limit;
        logic        e4_above;
        logic        e5_above;
        logic [7:0]  duty_out;
        logic        duty_hr;
    } fanlut_state_t;

    localparam fanlut_state_t FANLUT_RST = '{
        st:         FANLUT_IDLE,
        aw_got:     1'b0,
        w_got:      1'b0,
        aw_idx:     8'h00,
        aw_ok:      1'b0,
        w_data:     8'h00,
        w_lane0:    1'b0,
        bresp:      fanlut_pkg::RESP_OKAY,
        rdata:      32'h0000_0000,
        rresp:      fanlut_pkg::RESP_OKAY,
        cfg:        fanlut_pkg::CFG_RST,
        tbl_offset: fanlut_pkg::OFFSET_RST,
        e4_limit:   fanlut_pkg::E4_LIMIT_RST,
        e4_duty:    fanlut_pkg::E4_DUTY_RST,
        e5_limit:   fanlut_pkg::E5_LIMIT_RST,
        e4_above:   1'b0,
        e5_above:   1'b0,
        duty_out:   8'h00,
        duty_hr:    1'b0
    };

    fanlut_state_t q_ff;
    fanlut_state_t nxt_q;

    logic       temp_hires;
    logic       duty_hires;
    logic       pwm_22k5;
    logic       tbl_we;
    logic       cmp4_above;
    logic       cmp5_above;
    logic [7:0] duty_eff;
    logic       ext_active;

    assign temp_hires = q_ff.cfg[fanlut_pkg::CFG_TEMP_HIRES_BIT];
    assign duty_hires = q_ff.cfg[fanlut_pkg::CFG_DUTY_HIRES_BIT];
    assign pwm_22k5   = q_ff.cfg[fanlut_pkg::CFG_PWM_22K5_BIT];
    assign tbl_we     = q_ff.cfg[fanlut_pkg::CFG_TBL_WE_BIT];

    // Limit comparators for entries four and five
    fanlut_limit_cmp u_cmp4 (
        .remote_temp  (remote_temp),
        .limit        (q_ff.e4_limit),
        .table_offset (q_ff.tbl_offset),
        .temp_hires   (temp_hires),
        .above        (cmp4_above)
    );

    fanlut_limit_cmp u_cmp5 (
        .remote_temp  (remote_temp),
        .limit        (q_ff.e5_limit),
        .table_offset (q_ff.tbl_offset),
        .temp_hires   (temp_hires),
        .above        (cmp5_above)
    );

    fanlut_duty_fmt u_duty (
        .duty_reg   (q_ff.e4_duty),
        .duty_hires (duty_hires),
        .pwm_22k5   (pwm_22k5),
        .duty_eff   (duty_eff),
        .ext_active (ext_active)
    );

    // Writes take priority; a read waits while any write is pending
    assign awready = (q_ff.st == FANLUT_IDLE) && !q_ff.aw_got;
    assign wready  = (q_ff.st == FANLUT_IDLE) && !q_ff.w_got;
    assign arready = (q_ff.st == FANLUT_IDLE) && !q_ff.aw_got &&
                     !q_ff.w_got && !awvalid && !wvalid;
    assign bvalid  = (q_ff.st == FANLUT_WRESP);
    assign rvalid  = (q_ff.st == FANLUT_RRESP);
    assign bresp   = q_ff.bresp;
    assign rresp   = q_ff.rresp;
    assign rdata   = q_ff.rdata;

    assign entry4_active     = q_ff.e4_above;
    assign entry5_active     = q_ff.e5_above;
    assign entry4_duty       = q_ff.duty_out;
    assign duty_hires_active = q_ff.duty_hr;

    always_comb begin
        logic        aw_now;
        logic        w_now;
        logic [7:0]  idx;
        logic        ok;
        logic [7:0]  wd;
        logic        lane0;
        logic [7:0]  r_idx;
        logic        r_ok;
        logic [31:0] rd_word;

        nxt_q   = q_ff;
        aw_now  = awvalid && awready;
        w_now   = wvalid && wready;
        idx     = q_ff.aw_got ? q_ff.aw_idx : awaddr[9:2];
        ok      = q_ff.aw_got ? q_ff.aw_ok :
                  ((awaddr >> 10) == '0) && fanlut_pkg::is_mapped(idx);
        wd      = q_ff.w_got ? q_ff.w_data : wdata[7:0];
        lane0   = q_ff.w_got ? q_ff.w_lane0 : wstrb[0];
        r_idx   = araddr[9:2];
        r_ok    = ((araddr >> 10) == '0) && fanlut_pkg::is_mapped(r_idx);
        rd_word = 32'h0000_0000;

        // Read mux; reads never depend on the write-enable
        unique case (r_idx)
            fanlut_pkg::IDX_CFG:    rd_word[7:0] = q_ff.cfg;
            fanlut_pkg::IDX_OFFSET: rd_word[7:0] = q_ff.tbl_offset;
            fanlut_pkg::IDX_E4_LIMIT: begin
                rd_word[7:0] = {temp_hires &
                                q_ff.e4_limit[fanlut_pkg::LIMIT_HALF_BIT],
                                q_ff.e4_limit[6:0]};
            end
            fanlut_pkg::IDX_E4_DUTY: begin
                rd_word[7:0] = duty_hires ? q_ff.e4_duty :
                    {2'h0, q_ff.e4_duty[fanlut_pkg::DUTY_BASE_MSB:0]};
            end
            fanlut_pkg::IDX_E5_LIMIT: begin
                rd_word[7:0] = {temp_hires &
                                q_ff.e5_limit[fanlut_pkg::LIMIT_HALF_BIT],
                                q_ff.e5_limit[6:0]};
            end
            fanlut_pkg::IDX_STATUS: begin
                rd_word[fanlut_pkg::STAT_E4_BIT]  = q_ff.e4_above;
                rd_word[fanlut_pkg::STAT_E5_BIT]  = q_ff.e5_above;
                rd_word[fanlut_pkg::STAT_EXT_BIT] = q_ff.duty_hr;
                rd_word[fanlut_pkg::STAT_DUTY_LSB +: 8] = q_ff.duty_out;
            end
            default: rd_word = 32'h0000_0000;
        endcase

        unique case (q_ff.st)
            FANLUT_IDLE: begin
                if (aw_now) begin
                    nxt_q.aw_got = 1'b1;
                    nxt_q.aw_idx = idx;
                    nxt_q.aw_ok  = ok;
                end
                if (w_now) begin
                    nxt_q.w_got   = 1'b1;
                    nxt_q.w_data  = wd;
                    nxt_q.w_lane0 = lane0;
                end
                if ((q_ff.aw_got || aw_now) && (q_ff.w_got || w_now)) begin
                    nxt_q.st     = FANLUT_WRESP;
                    nxt_q.aw_got = 1'b0;
                    nxt_q.w_got  = 1'b0;
                    nxt_q.bresp  = ok ? fanlut_pkg::RESP_OKAY :
                                        fanlut_pkg::RESP_SLVERR;
                    if (ok && lane0) begin
                        unique case (idx)
                            fanlut_pkg::IDX_CFG: begin
                                nxt_q.cfg = wd & fanlut_pkg::CFG_WMASK;
                            end
                            fanlut_pkg::IDX_OFFSET: nxt_q.tbl_offset = wd;
                            fanlut_pkg::IDX_E4_LIMIT: begin
                                if (tbl_we) begin
                                    nxt_q.e4_limit = {temp_hires &
                                        wd[fanlut_pkg::LIMIT_HALF_BIT],
                                        wd[6:0]};
                                end
                            end
                            fanlut_pkg::IDX_E4_DUTY: begin
                                if (tbl_we) begin
                                    nxt_q.e4_duty = {duty_hires ?
                                        wd[fanlut_pkg::DUTY_EXT_MSB:
                                           fanlut_pkg::DUTY_EXT_LSB] : 2'h0,
                                        wd[fanlut_pkg::DUTY_BASE_MSB:0]};
                                end
                            end
                            fanlut_pkg::IDX_E5_LIMIT: begin
                                if (tbl_we) begin
                                    nxt_q.e5_limit = {temp_hires &
                                        wd[fanlut_pkg::LIMIT_HALF_BIT],
                                        wd[6:0]};
                                end
                            end
                            default: nxt_q.cfg = q_ff.cfg;
                        endcase
                    end
                end else if (arvalid && arready) begin
                    nxt_q.st    = FANLUT_RRESP;
                    nxt_q.rdata = r_ok ? rd_word : 32'h0000_0000;
                    nxt_q.rresp = r_ok ? fanlut_pkg::RESP_OKAY :
                                         fanlut_pkg::RESP_SLVERR;
                end
            end
            FANLUT_WRESP: begin
                if (bready) begin
                    nxt_q.st = FANLUT_IDLE;
                end
            end
            FANLUT_RRESP: begin
                if (rready) begin
                    nxt_q.st = FANLUT_IDLE;
                end
            end
            default: nxt_q.st = FANLUT_IDLE;
        endcase

        nxt_q.e4_above = cmp4_above;
        nxt_q.e5_above = cmp5_above;
        nxt_q.duty_out = duty_eff;
        nxt_q.duty_hr  = ext_active;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= FANLUT_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule // fanlut_entries
`default_nettype wire

// *** logic/fanlut_pkg.sv ***
`default_nettype none
package fanlut_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CFG      = 8'h4a;
    localparam logic [7:0] IDX_OFFSET   = 8'h4e;
    localparam logic [7:0] IDX_E4_LIMIT = 8'h56;
    localparam logic [7:0] IDX_E4_DUTY  = 8'h57;
    localparam logic [7:0] IDX_E5_LIMIT = 8'h58;
    localparam logic [7:0] IDX_STATUS   = 8'h60;

    // Configuration fields
    localparam int CFG_TEMP_HIRES_BIT = 0;
    localparam int CFG_DUTY_HIRES_BIT = 1;
    localparam int CFG_PWM_22K5_BIT   = 2;
    localparam int CFG_TBL_WE_BIT     = 5;
    localparam logic [7:0] CFG_WMASK  = 8'h27;

    // Limit and duty fields
    localparam int LIMIT_HALF_BIT   = 7;
    localparam int DUTY_EXT_MSB     = 7;
    localparam int DUTY_EXT_LSB     = 6;
    localparam int DUTY_BASE_MSB    = 5;

    // Status fields
    localparam int STAT_E4_BIT      = 0;
    localparam int STAT_E5_BIT      = 1;
    localparam int STAT_EXT_BIT     = 2;
    localparam int STAT_DUTY_LSB    = 8;

    // Reset values
    localparam logic [7:0] CFG_RST      = 8'h00;
    localparam logic [7:0] OFFSET_RST   = 8'h00;
    localparam logic [7:0] E4_LIMIT_RST = 8'h7f;
    localparam logic [7:0] E4_DUTY_RST  = 8'h3f;
    localparam logic [7:0] E5_LIMIT_RST = 8'h7f;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == IDX_CFG) || (idx == IDX_OFFSET) ||
                    (idx == IDX_E4_LIMIT) || (idx == IDX_E4_DUTY) ||
                    (idx == IDX_E5_LIMIT) || (idx == IDX_STATUS);
    endfunction

endpackage
`default_nettype wire

// *** logic/fanlut_limit_cmp.sv ***
`timescale 1ns/100ps
`default_nettype none
module fanlut_limit_cmp (
    // Filtered remote reading, degrees in [10:3], eighths in [2:0]
    input  wire logic [10:0] remote_temp,
    // Programmed limit and table offset
    input  wire logic [7:0]  limit,
    input  wire logic [7:0]  table_offset,
    input  wire logic        temp_hires,
    // Result
    output logic             above
);
    logic [10:0] temp_half;
    logic [10:0] limit_half;

    always_comb begin
        temp_half = {2'h0, remote_temp[10:3],
                     temp_hires & remote_temp[2]};
        limit_half = {3'h0, limit[6:0],
                      temp_hires & limit[fanlut_pkg::LIMIT_HALF_BIT]}
                   + {2'h0, table_offset, 1'b0};
        above = temp_half > limit_half;
    end
endmodule // fanlut_limit_cmp
`default_nettype wire

// *** logic/fanlut_duty_fmt.sv ***
`timescale 1ns/100ps
`default_nettype none
module fanlut_duty_fmt (
    // Stored duty entry and mode
    input  wire logic [7:0] duty_reg,
    input  wire logic       duty_hires,
    input  wire logic       pwm_22k5,
    // Duty handed to the PWM generator
    output logic [7:0]      duty_eff,
    output logic            ext_active
);
    always_comb begin
        ext_active = duty_hires & pwm_22k5;
        if (ext_active) begin
            duty_eff = duty_reg;
        end else begin
            duty_eff = {2'h0, duty_reg[fanlut_pkg::DUTY_BASE_MSB:0]};
        end
    end
endmodule // fanlut_duty_fmt
`default_nettype wire

// *** dv/fanlut_entries_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module fanlut_entries_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    // Fan side
    input wire logic [10:0] remote_temp,
    input wire logic        entry4_active,
    input wire logic        entry5_active,
    input wire logic [7:0]  entry4_duty,
    input wire logic        duty_hires_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A pending answer must refuse every new request
    property p_b_busy;
        bvalid |-> !awready && !wready && !arready;
    endproperty
    a_b_busy: assert property (p_b_busy)
        else $error("request accepted during write response");
    property p_r_busy;
        rvalid |-> !arready && !awready && !wready;
    endproperty
    a_r_busy: assert property (p_r_busy)
        else $error("request accepted during read response");
    property p_wr_resp;
        awvalid && awready && wvalid && wready |=> bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    property p_rd_resp; arvalid && arready |=> rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response late");
    property p_writes_win; awvalid || wvalid |-> !arready; endproperty
    a_writes_win: assert property (p_writes_win)
        else $error("read taken during write");
    // Extended duty bits must stay clear unless both modes agree
    property p_duty_low;
        !duty_hires_active |-> entry4_duty[7:6] == 2'b00;
    endproperty
    a_duty_low: assert property (p_duty_low)
        else $error("extended duty bits leak");
    property p_cold_temp;
        remote_temp == 11'h0 |=> !entry4_active && !entry5_active;
    endproperty
    a_cold_temp: assert property (p_cold_temp)
        else $error("zero reading marked above limit");
    // Mode only moves after a configuration write
    property p_hires_change;
        !$stable(duty_hires_active) |-> bvalid || $past(bvalid);
    endproperty
    a_hires_change: assert property (p_hires_change)
        else $error("duty mode changed without write");
endmodule // fanlut_entries_chk
`default_nettype wire

// *** dv/fanlut_entries_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fanlut_entries_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [9:0]  awaddr = 10'h0;
    logic [9:0]  araddr = 10'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [10:0] remote_temp = 11'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        entry4_active, entry5_active, duty_hires_active;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  entry4_duty;
    logic [1:0]  act;
    logic [8:0]  dty;
    logic [39:0] row;
    int          fails = 0;
    int          checks_done = 0;
    // Cfg, offset, reading, entry4 and entry5 expected
    logic [39:0] cmp_tab [10] = '{
        40'h21_00_002c_0_0, 40'h21_00_0030_1_0, 40'h20_00_002c_0_0,
        40'h20_00_0030_1_0, 40'h21_0a_007c_0_0, 40'h21_0a_0080_1_0,
        40'h21_0a_044c_1_1, 40'h20_0a_044c_1_0, 40'h20_0a_07ff_1_1,
        40'h21_00_0000_0_0};
    // Cfg, duty written, duty read, duty out, extended active
    logic [39:0] duty_tab [5] = '{
        40'h20_c5_05_05_00, 40'h22_c5_c5_05_00, 40'h26_c5_c5_c5_01,
        40'h24_c5_05_05_00, 40'h26_80_80_80_01};

    assign act = {entry5_active, entry4_active};
    assign dty = {entry4_duty, duty_hires_active};

    always #25 aclk = ~aclk;

    fanlut_entries dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .remote_temp(remote_temp), .entry4_active(entry4_active),
        .entry5_active(entry5_active), .entry4_duty(entry4_duty),
        .duty_hires_active(duty_hires_active)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Response ready goes up with the request and waits for the answer
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] st, input logic [1:0] er);
        logic got;
        got = 1'b0;
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        wstrb   <= st;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            got = bvalid && bready;
        end
        check(32'(bresp), 32'(er));
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
                      input logic [1:0] er);
        logic got;
        got = 1'b0;
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            got = rvalid && rready;
        end
        check(rdata, ed);
        check(32'(rresp), 32'(er));
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h56, 32'h7f, 2'h0);
        rd(8'h57, 32'h3f, 2'h0);
        rd(8'h58, 32'h7f, 2'h0);
        wr(8'h56, 8'h20, 4'hf, 2'h0);
        rd(8'h56, 32'h7f, 2'h0);
        rd(8'h59, 32'h0, 2'h2);
        wr(8'h00, 8'h20, 4'hf, 2'h2);
        wr(8'h4a, 8'h20, 4'hf, 2'h0);
        wr(8'h58, 8'h33, 4'h0, 2'h0);
        rd(8'h58, 32'h7f, 2'h0);
        wr(8'h56, 8'h85, 4'hf, 2'h0);
        rd(8'h56, 32'h05, 2'h0);
        wr(8'h4a, 8'h21, 4'hf, 2'h0);
        wr(8'h56, 8'h85, 4'hf, 2'h0);
        rd(8'h56, 32'h85, 2'h0);
        for (int i = 0; i < 10; i++) begin
            row = cmp_tab[i];
            wr(8'h4a, row[39:32], 4'hf, 2'h0);
            wr(8'h4e, row[31:24], 4'hf, 2'h0);
            remote_temp <= row[18:8];
            repeat (2) @(posedge aclk);
            check(32'(act), 32'({row[0], row[4]}));
        end
        wr(8'h4a, 8'h20, 4'hf, 2'h0);
        wr(8'h58, 8'hff, 4'hf, 2'h0);
        rd(8'h58, 32'h7f, 2'h0);
        remote_temp <= 11'h640;
        for (int i = 0; i < 5; i++) begin
            row = duty_tab[i];
            wr(8'h4a, row[39:32], 4'hf, 2'h0);
            wr(8'h57, row[31:24], 4'hf, 2'h0);
            rd(8'h57, 32'(row[23:16]), 2'h0);
            rd(8'h60, {16'h0, row[15:8], 5'h0, row[0], 2'h3}, 2'h0);
            check(32'(dty), 32'({row[15:8], row[0]}));
        end
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h57, 32'h3f, 2'h0);
        check(32'(dty), 32'h7e);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        report_and_stop();
    end
endmodule // fanlut_entries_tb

bind fanlut_entries fanlut_entries_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .remote_temp(remote_temp), .entry4_active(entry4_active),
    .entry5_active(entry5_active), .entry4_duty(entry4_duty),
    .duty_hires_active(duty_hires_active)
);
`default_nettype wire
